// ==== rtl/clkgen_defines.svh ====
// constants for the clock generator and start-up sequencer
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// timing
`define CG_CLK_MHZ 25
`define CG_STAB_US 1930
`define CG_RSTPROC_US 19
`define CG_SETTLE_BASE 11

// register byte offsets
`define CG_ADDR_CTRL 8'h00
`define CG_ADDR_CLKSEL 8'h04
`define CG_ADDR_STATUS 8'h08
`define CG_ADDR_SETTLE_SEL 8'h0c

// control register fields
`define CG_CTRL_MAIN_HALT 0
`define CG_CTRL_SUB_HALT 1
`define CG_CTRL_INT_HALT 2
`define CG_CTRL_EXT_MODE 3
`define CG_CTRL_MAIN_PINSEL 4
`define CG_CTRL_SUB_PINSEL 5
`define CG_CTRL_STOP 6
`define CG_CTRL_RESET 6'h03

// status register fields
`define CG_STAT_MAIN_FLAG 0
`define CG_STAT_SUB_FLAG 1
`define CG_STAT_MAIN_ACT 2
`define CG_STAT_SUB_ACT 3
`define CG_STAT_INT_ACT 4
`define CG_STAT_CPU_RUN 5
`define CG_STAT_BUSY 6
`define CG_STAT_SETTLE_LSB 8

// other reset values
`define CG_SETTLE_SEL_RESET 3'h4
`define CG_SETTLE_STEPS 5

`endif

// ==== rtl/clkgen_pkg.sv ====
// types shared by the clock generator files
package clkgen_pkg;
    typedef enum logic [1:0] {SRC_INT, SRC_MAIN, SRC_SUB} cpu_src_t;
    typedef enum {SEQ_POR_HOLD, SEQ_STAB, SEQ_RSTPROC, SEQ_RUN, SEQ_STOP, SEQ_SETTLE} seq_state_t;
    typedef enum {SW_ON, SW_GAP} sw_state_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_in_t;
    typedef struct packed {
        logic int_hs;
        logic main;
        logic sub;
    } osc_act_t;
endpackage

// ==== rtl/cpu_clock_switch.sv ====
// break-before-make selector for the CPU clock source
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_switch
    import clkgen_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hold_int,
    input wire cpu_src_t req,
    input wire osc_act_t act,
    output var cpu_src_t cur,
    output logic [2:0] grant,
    output logic busy
);
    sw_state_t state;

    function automatic logic src_running(input cpu_src_t s, input osc_act_t a);
        unique case (s)
            SRC_INT: src_running = a.int_hs;
            SRC_MAIN: src_running = a.main;
            SRC_SUB: src_running = a.sub;
            default: src_running = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] onehot(input cpu_src_t s);
        onehot = 3'h1 << s;
    endfunction

    // reset forces the internal oscillator; otherwise hand over only when both run
    wire cpu_src_t want = hold_int ? SRC_INT : req;
    wire logic can_switch = (want != cur) && src_running(want, act) && src_running(cur, act);
    assign busy = (want != cur) || (state == SW_GAP);

    // one dead cycle with no grant keeps any clock pulse from being cut short
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= SW_ON;
            cur <= SRC_INT;
            grant <= 3'h1;
        end else if (hold_int) begin
            state <= SW_ON;
            cur <= SRC_INT;
            grant <= 3'h1;
        end else if (state == SW_GAP) begin
            state <= SW_ON;
            grant <= onehot(cur);
        end else if (can_switch) begin
            state <= SW_GAP;
            cur <= want;
            grant <= 3'h0;
        end
    end

    sequence s_gap_then_new;
        grant == 3'h0 ##1 grant == onehot(cur);
    endsequence

    a_grant_one_hot: assert property (@(posedge clock) disable iff (!rst_n) $onehot0(grant))
        else $error("cpu clock grant has more than one source");
    a_handover_gap: assert property (@(posedge clock) disable iff (!rst_n)
        ($changed(cur) && !$past(hold_int) && !hold_int) |-> s_gap_then_new)
        else $error("cpu clock handover without a dead cycle");
endmodule
`default_nettype wire

// ==== rtl/clock_generator_startup_sequencer.sv ====
// clock generator start-up sequencer with wishbone register slave
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
module clock_generator_startup_sequencer
    import clkgen_pkg::*;
#(
    parameter int STAB_CYCLES = `CG_STAB_US * `CG_CLK_MHZ,
    parameter int SETTLE_BASE = `CG_SETTLE_BASE
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire wb_in_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic vdd_above_low,
    input wire logic vdd_above_high,
    input wire logic reset_pin_n,
    input wire logic poweron_threshold_select,
    input wire logic wake_event,
    input wire osc_act_t osc_active,
    output logic int_reset_n,
    output logic reset_processing,
    output logic cpu_run,
    output logic int_osc_en,
    output logic main_osc_en,
    output logic ext_main_clock_in_en,
    output logic sub_osc_en,
    output logic x1_pin_is_port,
    output logic x2_pin_is_port,
    output logic sub_pins_are_port,
    output logic [2:0] cpu_clock_grant
);
    localparam int RSTPROC_CYCLES = `CG_RSTPROC_US * `CG_CLK_MHZ;
    localparam int STAB_W = $clog2(STAB_CYCLES + 1);
    localparam int RP_W = $clog2(RSTPROC_CYCLES + 1);
    localparam int SET_W = SETTLE_BASE + `CG_SETTLE_STEPS;

    // two-stage synchronisers for every pin and analog status input
    logic [7:0] sync1;
    logic [7:0] sync2;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {osc_active, wake_event, poweron_threshold_select,
                      reset_pin_n, vdd_above_high, vdd_above_low};
            sync2 <= sync1;
        end
    end
    wire logic vdd_low_s = sync2[0];
    wire logic vdd_high_s = sync2[1];
    wire logic pin_rel_s = sync2[2];
    wire logic strap_s = sync2[3];
    wire logic wake_s = sync2[4];
    wire osc_act_t act_s = sync2[7:5];

    seq_state_t seq;
    logic dual_mode;
    logic [STAB_W-1:0] stab_cnt;
    logic [RP_W-1:0] rp_cnt;
    logic [5:0] ctrl;
    cpu_src_t clksel;
    logic [2:0] settle_sel;
    logic [SET_W-1:0] settle_cnt;
    cpu_src_t cur_src;
    logic sw_busy;

    // strap is re-caught every cycle while held in reset, never at the async edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dual_mode <= 1'b0;
        end else if (seq == SEQ_POR_HOLD) begin
            dual_mode <= strap_s;
        end
    end

    // settling counter runs from the lower-threshold crossing onward
    wire logic supply_ok = vdd_low_s && pin_rel_s;
    wire logic stab_done = stab_cnt >= STAB_W'(STAB_CYCLES);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stab_cnt <= '0;
        end else if (!supply_ok) begin
            stab_cnt <= '0;
        end else if (!stab_done) begin
            stab_cnt <= stab_cnt + 1'b1;
        end
    end

    // release threshold depends on the captured power-on mode
    wire logic release_ok = supply_ok && (dual_mode ? vdd_high_s : 1'b1);
    wire logic rp_done = rp_cnt >= RP_W'(RSTPROC_CYCLES - 1);
    wire logic stop_req = wb_ack_o && wb_i.we && wb_i.sel[0] && (wb_i.adr == `CG_ADDR_CTRL)
        && wb_i.dat[`CG_CTRL_STOP];
    wire logic ext_mode = ctrl[`CG_CTRL_EXT_MODE];
    logic [`CG_SETTLE_STEPS-1:0] settle_stat;
    wire logic resume_ok = (cur_src != SRC_MAIN) || ext_mode || settle_stat[settle_sel];

    // sequencer: hold, settle, reset processing, run, standby
    seq_state_t next_seq;
    always_comb begin
        next_seq = seq;
        unique case (seq)
            SEQ_POR_HOLD: if (release_ok) next_seq = SEQ_STAB;
            SEQ_STAB: if (stab_done) next_seq = SEQ_RSTPROC;
            SEQ_RSTPROC: if (rp_done) next_seq = SEQ_RUN;
            SEQ_RUN: if (stop_req) next_seq = SEQ_STOP;
            SEQ_STOP: if (wake_s) next_seq = SEQ_SETTLE;
            SEQ_SETTLE: if (resume_ok) next_seq = SEQ_RUN;
        endcase
        if (!release_ok && !(seq == SEQ_RUN || seq == SEQ_STOP || seq == SEQ_SETTLE)) begin
            next_seq = SEQ_POR_HOLD;
        end
        if (!supply_ok) begin
            next_seq = SEQ_POR_HOLD;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq <= SEQ_POR_HOLD;
            rp_cnt <= '0;
        end else begin
            seq <= next_seq;
            rp_cnt <= (seq == SEQ_RSTPROC) ? rp_cnt + 1'b1 : '0;
        end
    end
    wire logic in_hold = (seq == SEQ_POR_HOLD);
    wire logic in_boot = in_hold || (seq == SEQ_STAB) || (seq == SEQ_RSTPROC);
    wire logic in_standby = (seq == SEQ_STOP);

    // a halt bit for the source that feeds the CPU cannot be set
    function automatic logic [5:0] ctrl_write(input logic [5:0] old, input logic [31:0] d,
                                              input cpu_src_t src);
        logic [5:0] v;
        v = d[5:0];
        if (src == SRC_MAIN) v[`CG_CTRL_MAIN_HALT] = old[`CG_CTRL_MAIN_HALT];
        if (src == SRC_SUB) v[`CG_CTRL_SUB_HALT] = old[`CG_CTRL_SUB_HALT];
        if (src == SRC_INT) v[`CG_CTRL_INT_HALT] = old[`CG_CTRL_INT_HALT];
        ctrl_write = v;
    endfunction

    // wishbone classic slave: one wait state, write lands on the ack edge
    wire logic wb_req = wb_i.cyc && wb_i.stb;
    wire logic wr_low = wb_ack_o && wb_i.we && wb_i.sel[0];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (wb_i.adr)
            `CG_ADDR_CTRL: rd_mux = {26'h0, ctrl};
            `CG_ADDR_CLKSEL: rd_mux = {30'h0, clksel};
            `CG_ADDR_SETTLE_SEL: rd_mux = {29'h0, settle_sel};
            `CG_ADDR_STATUS: begin
                rd_mux[`CG_STAT_MAIN_FLAG] = (cur_src == SRC_MAIN);
                rd_mux[`CG_STAT_SUB_FLAG] = (cur_src == SRC_SUB);
                rd_mux[`CG_STAT_MAIN_ACT] = act_s.main;
                rd_mux[`CG_STAT_SUB_ACT] = act_s.sub;
                rd_mux[`CG_STAT_INT_ACT] = act_s.int_hs;
                rd_mux[`CG_STAT_CPU_RUN] = cpu_run;
                rd_mux[`CG_STAT_BUSY] = sw_busy;
                rd_mux[`CG_STAT_SETTLE_LSB +: `CG_SETTLE_STEPS] = settle_stat;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            wb_dat_o <= (wb_req && !wb_ack_o && !wb_i.we) ? rd_mux : 32'h0;
        end
    end

    // registers return to reset values while the internal reset is held
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `CG_CTRL_RESET;
            clksel <= SRC_INT;
            settle_sel <= `CG_SETTLE_SEL_RESET;
        end else if (in_hold) begin
            ctrl <= `CG_CTRL_RESET;
            clksel <= SRC_INT;
            settle_sel <= `CG_SETTLE_SEL_RESET;
        end else if (wr_low) begin
            unique case (wb_i.adr)
                `CG_ADDR_CTRL: ctrl <= ctrl_write(ctrl, wb_i.dat, cur_src);
                `CG_ADDR_CLKSEL: clksel <= (wb_i.dat[1:0] == 2'h3) ? clksel : cpu_src_t'(wb_i.dat[1:0]);
                `CG_ADDR_SETTLE_SEL: settle_sel <= (wb_i.dat[2:0] > 3'h4) ? 3'h4 : wb_i.dat[2:0];
                default: ;
            endcase
        end
    end

    // source enables; standby stops internal and high-speed clocks only
    wire logic next_int_en = !in_hold && !in_standby && !ctrl[`CG_CTRL_INT_HALT];
    wire logic main_on = ctrl[`CG_CTRL_MAIN_PINSEL] && !ctrl[`CG_CTRL_MAIN_HALT];
    wire logic next_main_en = main_on && !ext_mode && !in_standby && !in_boot;
    wire logic next_ext_en = main_on && ext_mode && !in_standby && !in_boot;
    wire logic next_sub_en = ctrl[`CG_CTRL_SUB_PINSEL] && !ctrl[`CG_CTRL_SUB_HALT] && !in_boot;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_osc_en <= 1'b0;
            main_osc_en <= 1'b0;
            ext_main_clock_in_en <= 1'b0;
            sub_osc_en <= 1'b0;
            x1_pin_is_port <= 1'b1;
            x2_pin_is_port <= 1'b1;
            sub_pins_are_port <= 1'b1;
            int_reset_n <= 1'b0;
            reset_processing <= 1'b0;
            cpu_run <= 1'b0;
        end else begin
            int_osc_en <= next_int_en;
            main_osc_en <= next_main_en;
            ext_main_clock_in_en <= next_ext_en;
            sub_osc_en <= next_sub_en;
            x1_pin_is_port <= !ctrl[`CG_CTRL_MAIN_PINSEL] || ext_mode;
            x2_pin_is_port <= !ctrl[`CG_CTRL_MAIN_PINSEL];
            sub_pins_are_port <= !ctrl[`CG_CTRL_SUB_PINSEL];
            int_reset_n <= !(next_seq == SEQ_POR_HOLD);
            reset_processing <= (next_seq == SEQ_RSTPROC);
            cpu_run <= (next_seq == SEQ_RUN);
        end
    end

    // crystal settling counter; restarts whenever the oscillator is off
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= '0;
        end else if (!main_osc_en || !act_s.main) begin
            settle_cnt <= '0;
        end else if (!settle_cnt[SET_W-1]) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // thermometer steps at 2^base .. 2^(base+4); external input counts as settled
    genvar gi;
    generate
        for (gi = 0; gi < `CG_SETTLE_STEPS; gi++) begin : g_settle
            assign settle_stat[gi] = ext_main_clock_in_en ||
                (settle_cnt >= SET_W'(1 << (SETTLE_BASE + gi)));
        end
    endgenerate

    // only sources that are enabled and seen running may feed the CPU
    wire osc_act_t act_eff = '{int_hs: act_s.int_hs && int_osc_en,
                               main: act_s.main && (main_osc_en || ext_main_clock_in_en),
                               sub: act_s.sub && sub_osc_en};

    cpu_clock_switch u_switch (
        .clock(clock),
        .rst_n(rst_n),
        .hold_int(in_boot),
        .req(clksel),
        .act(act_eff),
        .cur(cur_src),
        .grant(cpu_clock_grant),
        .busy(sw_busy)
    );

    // length of the running reset-processing phase; a counter, since it spans hundreds of cycles
    logic [RP_W-1:0] rp_seen;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rp_seen <= '0;
        end else begin
            rp_seen <= reset_processing ? rp_seen + 1'b1 : '0;
        end
    end

    a_por_holds_reset: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(supply_ok) |-> !int_reset_n)
        else $error("internal reset released without supply");
    a_boot_on_int: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cpu_run) && $past(seq == SEQ_RSTPROC, 2) |-> cur_src == SRC_INT)
        else $error("cpu started on a source other than internal oscillator");
    a_rstproc_length: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(reset_processing) && $past(release_ok) |-> rp_seen >= RP_W'(RSTPROC_CYCLES))
        else $error("reset processing cut short");
    a_stab_before_proc: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(reset_processing) |-> $past(stab_done))
        else $error("reset processing before supply settling");
    a_dual_threshold: assert property (@(posedge clock) disable iff (!rst_n)
        (seq == SEQ_STAB) && dual_mode |-> $past(vdd_high_s))
        else $error("dual mode released below upper threshold");
    a_no_auto_crystal: assert property (@(posedge clock) disable iff (!rst_n)
        reset_processing |-> !main_osc_en && !sub_osc_en)
        else $error("crystal started by reset sequence");
    a_stop_halts_clocks: assert property (@(posedge clock) disable iff (!rst_n)
        $past(seq == SEQ_STOP) && (seq == SEQ_STOP) |-> !int_osc_en && !main_osc_en)
        else $error("standby left an oscillator running");
    a_feeding_not_halted: assert property (@(posedge clock) disable iff (!rst_n)
        (cur_src == SRC_MAIN) && $past(cur_src == SRC_MAIN) |-> !ctrl[`CG_CTRL_MAIN_HALT])
        else $error("main oscillator halted while feeding cpu");
endmodule
`default_nettype wire

// ==== tb/clkgen_far_side.sv ====
// supply, reset pin and resonator model facing the clock generator
`timescale 1ns/1ps
`default_nettype none
module clkgen_far_side
    import clkgen_pkg::*;
#(
    parameter int LOW_DELAY = 10,
    parameter int HIGH_DELAY = 60,
    parameter int MAIN_START = 30,
    parameter int SUB_START = 40
) (
    input wire logic clock,
    input wire logic power_on,
    input wire logic pin_hold,
    input wire logic int_osc_en,
    input wire logic main_osc_en,
    input wire logic ext_main_clock_in_en,
    input wire logic sub_osc_en,
    output logic vdd_above_low,
    output logic vdd_above_high,
    output logic reset_pin_n,
    output var osc_act_t osc_active
);
    int sup = 0;
    int mc = 0;
    int sc = 0;
    // supply ramp and crystal start-up, all restart from zero when off
    always @(posedge clock) begin
        sup <= power_on ? sup + 1 : 0;
        mc <= main_osc_en ? mc + 1 : 0;
        sc <= sub_osc_en ? sc + 1 : 0;
    end
    // comparators follow the ramp
    assign vdd_above_low = power_on && sup >= LOW_DELAY;
    assign vdd_above_high = power_on && sup >= HIGH_DELAY;
    // board keeps the pin low until the supply is safe
    assign reset_pin_n = !pin_hold && vdd_above_low;
    // a crystal only runs after its start-up time; external input at once
    assign osc_active = '{int_hs: int_osc_en,
                          main: (mc >= MAIN_START) || ext_main_clock_in_en,
                          sub: sc >= SUB_START};
endmodule
`default_nettype wire

// ==== tb/clock_generator_startup_sequencer_tb.sv ====
// self-checking bench for the clock generator start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
`define CHK(nm, exp, got) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module clock_generator_startup_sequencer_tb
    import clkgen_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wb_in_t wb_i = '0;
    logic power_on = 1'b0;
    logic pin_hold = 1'b0;
    logic dual = 1'b0;
    logic wake_event = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, vdd_above_low, vdd_above_high, reset_pin_n, int_reset_n;
    logic reset_processing, cpu_run, int_osc_en, main_osc_en, ext_main_clock_in_en;
    logic sub_osc_en, x1_pin_is_port, x2_pin_is_port, sub_pins_are_port;
    logic [2:0] cpu_clock_grant;
    osc_act_t osc_active;
    logic [31:0] q;
    logic hi_rp;
    int gaps = 0;
    int mismatches = 0;
    int checks_done = 0;
    int n, t_rp;

    // 25 MHz system clock
    always #20 clock = ~clock;

    // settle counts shortened so the run stays short
    clock_generator_startup_sequencer #(.STAB_CYCLES(20), .SETTLE_BASE(2)) dut (
        .clock(clock), .rst_n(rst_n), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .vdd_above_low(vdd_above_low),
        .vdd_above_high(vdd_above_high), .reset_pin_n(reset_pin_n),
        .poweron_threshold_select(dual), .wake_event(wake_event),
        .osc_active(osc_active), .int_reset_n(int_reset_n),
        .reset_processing(reset_processing), .cpu_run(cpu_run),
        .int_osc_en(int_osc_en), .main_osc_en(main_osc_en),
        .ext_main_clock_in_en(ext_main_clock_in_en), .sub_osc_en(sub_osc_en),
        .x1_pin_is_port(x1_pin_is_port), .x2_pin_is_port(x2_pin_is_port),
        .sub_pins_are_port(sub_pins_are_port), .cpu_clock_grant(cpu_clock_grant));

    clkgen_far_side far (.clock(clock), .power_on(power_on), .pin_hold(pin_hold),
        .int_osc_en(int_osc_en), .main_osc_en(main_osc_en),
        .ext_main_clock_in_en(ext_main_clock_in_en), .sub_osc_en(sub_osc_en),
        .vdd_above_low(vdd_above_low), .vdd_above_high(vdd_above_high),
        .reset_pin_n(reset_pin_n), .osc_active(osc_active));

    // counts all-off cycles of clock handovers; one driver, so tasks only read it
    always @(posedge clock) begin
        if (cpu_clock_grant === 3'b000) gaps <= gaps + 1;
    end

    // one classic cycle; the request holds until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1);
        `CHK("ack_wait", 2, k)
        q = wb_dat_o;
        wb_i <= '0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic ticks(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic note(input string s);
        $display("done: %s", s);
    endtask

    // waits through hold, settle and reset processing, then checks boot state
    task automatic boot(input logic hi_exp, input int min_wait);
        int rp;
        rp = 0;
        t_rp = 0;
        for (n = 0; n < 3000 && cpu_run !== 1'b1; n++) begin
            @(posedge clock);
            if (reset_processing === 1'b1) begin
                if (rp == 0) t_rp = n;
                if (rp == 0) hi_rp = vdd_above_high;
                rp++;
            end
        end
        `CHK("rst_proc_len", 475, rp)
        `CHK("settle_wait", 1'b1, t_rp >= min_wait)
        `CHK("upper_at_release", hi_exp, hi_rp)
        `CHK("int_reset_n", 1'b1, int_reset_n)
        `CHK("grant_int", 3'b001, cpu_clock_grant)
        `CHK("int_osc_on", 1'b1, int_osc_en)
        `CHK("crystals_off", 2'b00, {main_osc_en, sub_osc_en})
        `CHK("pins_port", 3'b111, {x1_pin_is_port, x2_pin_is_port, sub_pins_are_port})
        rd(`CG_ADDR_CTRL);
        `CHK("ctrl_reset", 32'h03, q & 32'h3f)
        rd(`CG_ADDR_CLKSEL);
        `CHK("clksel_reset", 32'h0, q & 32'h3)
        rd(`CG_ADDR_SETTLE_SEL);
        `CHK("settle_sel_reset", 32'h4, q & 32'h7)
        rd(8'h10);
        `CHK("unmapped", 32'h0, q)
        rd(`CG_ADDR_STATUS);
        `CHK("flags_reset", 2'b00, q[1:0])
    endtask

    // hands the CPU to another source and checks the status flags
    task automatic sw(input logic [31:0] sel, input logic [2:0] g, input logic [1:0] f);
        int g0;
        g0 = gaps;
        wr(`CG_ADDR_CLKSEL, sel);
        for (n = 0; n < 200 && cpu_clock_grant !== g; n++) @(posedge clock);
        `CHK("grant", g, cpu_clock_grant)
        `CHK("grant_gap", 1, gaps - g0)
        rd(`CG_ADDR_STATUS);
        `CHK("cpu_flags", f, {q[1], q[0] & ~q[1]})
    endtask

    task automatic print_verdict();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        power_on <= 1'b1;
        ticks(5);
        `CHK("por_hold", 2'b00, {int_reset_n, cpu_run})
        boot(1'b0, 25);
        note("power-up low threshold");
        wr(`CG_ADDR_CTRL, 32'h30);
        rd(`CG_ADDR_STATUS);
        `CHK("settle_early", 1'b1, q[12:8] !== 5'h1f)
        `CHK("crystal_en", 2'b11, {main_osc_en, sub_osc_en})
        `CHK("pins_osc", 3'b000, {x1_pin_is_port, x2_pin_is_port, sub_pins_are_port})
        ticks(150);
        rd(`CG_ADDR_STATUS);
        `CHK("settle_done", 5'h1f, q[12:8])
        sw(32'h1, 3'b010, 2'b01);
        sw(32'h2, 3'b100, 2'b10);
        sw(32'h1, 3'b010, 2'b01);
        note("crystal start and switching");
        wr(`CG_ADDR_CLKSEL, 32'h3);
        rd(`CG_ADDR_CLKSEL);
        `CHK("clksel_bad", 32'h1, q & 32'h3)
        wr(`CG_ADDR_CTRL, 32'h35);
        rd(`CG_ADDR_CTRL);
        `CHK("halt_in_use", 32'h34, q & 32'h3f)
        `CHK("int_off", 2'b01, {int_osc_en, main_osc_en})
        note("stopping idle sources");
        wr(`CG_ADDR_SETTLE_SEL, 32'h7);
        rd(`CG_ADDR_SETTLE_SEL);
        `CHK("settle_sel_clamp", 32'h4, q & 32'h7)
        wr(`CG_ADDR_SETTLE_SEL, 32'h2);
        wr(`CG_ADDR_CTRL, 32'h74);
        ticks(4);
        `CHK("stop_halts", 4'b0001, {int_osc_en, main_osc_en, cpu_run, sub_osc_en})
        wake_event <= 1'b1;
        for (n = 0; n < 2000 && cpu_run !== 1'b1; n++) @(posedge clock);
        wake_event <= 1'b0;
        `CHK("wake_wait", 1'b1, n >= 16 && n < 2000)
        note("standby on crystal");
        pin_hold <= 1'b1;
        ticks(8);
        `CHK("pin_reset", 2'b00, {int_reset_n, cpu_run})
        pin_hold <= 1'b0;
        boot(1'b1, 20);
        note("reset pin");
        wr(`CG_ADDR_CTRL, 32'h1a);
        rd(`CG_ADDR_STATUS);
        `CHK("ext_settle", 5'h1f, q[12:8])
        `CHK("ext_pins", 3'b110, {ext_main_clock_in_en, x1_pin_is_port, x2_pin_is_port})
        sw(32'h1, 3'b010, 2'b01);
        note("external clock");
        rst_n <= 1'b0;
        power_on <= 1'b0;
        dual <= 1'b1;
        ticks(4);
        rst_n <= 1'b1;
        power_on <= 1'b1;
        boot(1'b1, 60);
        note("power-up dual threshold");
        print_verdict();
    end
endmodule
`default_nettype wire
